// File: src/ptc_pkg.sv
package ptc_pkg;
   // Register byte offsets on the plain register port
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_CMD       = 8'h04;
   localparam logic [7:0] ADDR_PERIOD    = 8'h08;
   localparam logic [7:0] ADDR_CMP0      = 8'h0C;
   localparam logic [7:0] ADDR_CMP1      = 8'h10;
   localparam logic [7:0] ADDR_CMP2      = 8'h14;
   localparam logic [7:0] ADDR_STATE     = 8'h18;
   localparam logic [7:0] ADDR_MODE      = 8'h1C;
   localparam logic [7:0] ADDR_COUNT     = 8'h20;

   // Control register field positions
   localparam int CTRL_DIV_LSB           = 0;
   localparam int CTRL_PRE_BIT           = 3;
   localparam int CTRL_ALIGN_BIT         = 4;
   localparam int CTRL_SSHOT_BIT         = 5;
   localparam int CTRL_SRC_LSB           = 6;
   localparam int CTRL_STE_BIT           = 8;
   localparam int CTRL_RUN_BIT           = 9;
   localparam int CTRL_DIR_BIT           = 10;

   // Command register bits, write-only
   localparam int CMD_RUN_SET_BIT        = 0;
   localparam int CMD_RUN_CLR_BIT        = 1;
   localparam int CMD_STEP_BIT           = 2;
   localparam int CMD_STE_SET_BIT        = 3;
   localparam int CMD_STE_CLR_BIT        = 4;

   // State modify layout: set bits low, clear bits from here
   localparam int STATE_CLR_LSB          = 8;

   // Extra prescale adds this many binary divide stages (1/256)
   localparam int EXTRA_PRE_STAGES       = 8;
   localparam int PRESC_WIDTH            = 15;

   // Hysteresis-like channel mode code
   localparam logic [3:0] MODE_HYST      = 4'h9;

   // Reset values
   localparam logic [15:0] PERIOD_RST    = 16'h0000;
   localparam logic [15:0] CMP_RST       = 16'h0000;
   localparam logic [15:0] COUNT_RST     = 16'h0000;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   // Count source encodings
   typedef enum logic [1:0] {
      SRC_PRESC = 2'b00,
      SRC_SOFT  = 2'b01,
      SRC_RISE  = 2'b10,
      SRC_FALL  = 2'b11
   } ptc_src_type;
endpackage : ptc_pkg

// File: src/ptc_core.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Source 00: module clock through 1..128 prescaler
// - Extra prescale bit divides further by 256
// - Prescaler held cleared while run flag zero
// - Source 01: software step bit advances counter
// - Source 10: external input rising edge steps
// - Source 11: external input falling edge steps
// - Edge-aligned: count up, clear after period
// - Center: period match up turns direction down
// - Center: one match down turns direction up
// - Direction zero increments, one decrements
// - Single shot clears run at period end
// - Edge single shot stops on wrap to zero
// - Center single shot stops reaching zero down
// - Three equality comparators, shadowed compare values
// - Software sets or clears state bits directly
// - Up and down match events ignore state
// - Match and zero switching acts only while running; hysteresis hold acts while stopped too
// - Match counting up sets state next step
// - Match counting down clears state next step
// - Zero match up without match clears state
// - Hysteresis mode: position low holds state zero
// - Position inputs sampled by module clock
// - Position inputs ignored outside hysteresis mode
// - Period reads active, writes shadow, transfer copies
// - Separate run set and clear command bits
// - Zero match and one match decoded
module ptc_core #(
   parameter int CNT_WIDTH = 16,
   parameter int NUM_CH    = 3
) (
   input  wire logic                    mclk,
   input  wire logic                    rstn,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [31:0]                  reg_rdata,
   input  wire logic                    external_timer_input,
   input  wire logic [NUM_CH-1:0]       position_input,
   output logic [NUM_CH-1:0]            channel_state_bit,
   output logic [NUM_CH-1:0]            up_match_event,
   output logic [NUM_CH-1:0]            down_match_event,
   output logic [CNT_WIDTH-1:0]         main_pwm_counter,
   output logic                         count_direction_flag,
   output logic                         run_flag,
   output logic                         period_match
);
   import ptc_pkg::*;

   // Mask of low prescaler bits that must be all ones for a tick
   function automatic logic [PRESC_WIDTH-1:0] div_mask(input logic [2:0] sel, input logic pre);
      logic [4:0] n;
      n = {2'b00, sel} + (pre ? 5'(EXTRA_PRE_STAGES) : 5'd0);
      div_mask = PRESC_WIDTH'((32'h1 << n) - 32'h1);
   endfunction : div_mask

   // Software-visible control state
   logic [2:0]                clk_div_ff;
   logic                      pre_ff;
   logic                      align_ff;
   logic                      sshot_ff;
   ptc_src_type               src_ff;
   logic                      ste_ff;
   logic                      nxt_ste;
   logic                      run_ff;
   logic                      nxt_run;
   logic                      dir_ff;
   logic                      nxt_dir;
   logic [CNT_WIDTH-1:0]      cnt_ff;
   logic [CNT_WIDTH-1:0]      nxt_cnt;
   logic [CNT_WIDTH-1:0]      per_sh_ff;
   logic [CNT_WIDTH-1:0]      per_act_ff;
   logic [CNT_WIDTH-1:0]      cmp_sh_ff  [NUM_CH];
   logic [CNT_WIDTH-1:0]      cmp_act_ff [NUM_CH];
   logic [4*NUM_CH-1:0]       mode_ff;
   logic [NUM_CH-1:0]         state_ff;
   logic [NUM_CH-1:0]         nxt_state;
   logic [NUM_CH-1:0]         up_ev_ff;
   logic [NUM_CH-1:0]         dn_ev_ff;
   logic [PRESC_WIDTH-1:0]    presc_ff;
   logic [31:0]               rdata_ff;

   // Synchronisers; the first stages feed only the second stages
   logic                      ext_s1_ff;
   logic                      ext_s2_ff;
   logic                      ext_d_ff;
   logic [NUM_CH-1:0]         pos_s1_ff;
   logic [NUM_CH-1:0]         pos_s2_ff;

   // Register decode
   wire wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL);
   wire wr_cmd    = reg_wr && (reg_addr == ADDR_CMD);
   wire wr_period = reg_wr && (reg_addr == ADDR_PERIOD);
   wire wr_state  = reg_wr && (reg_addr == ADDR_STATE);
   wire wr_mode   = reg_wr && (reg_addr == ADDR_MODE);
   wire wr_count  = reg_wr && (reg_addr == ADDR_COUNT);
   wire [NUM_CH-1:0] wr_cmp;
   assign wr_cmp[0] = reg_wr && (reg_addr == ADDR_CMP0);
   assign wr_cmp[1] = reg_wr && (reg_addr == ADDR_CMP1);
   assign wr_cmp[2] = reg_wr && (reg_addr == ADDR_CMP2);

   wire cmd_run_set = wr_cmd && reg_wdata[CMD_RUN_SET_BIT];
   wire cmd_run_clr = wr_cmd && reg_wdata[CMD_RUN_CLR_BIT];
   wire cmd_step    = wr_cmd && reg_wdata[CMD_STEP_BIT];
   wire cmd_ste_set = wr_cmd && reg_wdata[CMD_STE_SET_BIT];
   wire cmd_ste_clr = wr_cmd && reg_wdata[CMD_STE_CLR_BIT];
   wire [NUM_CH-1:0] sw_set = wr_state ? reg_wdata[NUM_CH-1:0] : '0;
   wire [NUM_CH-1:0] sw_clr = wr_state ? reg_wdata[STATE_CLR_LSB +: NUM_CH] : '0;

   // Counter decodes shared by all channels
   wire zero_m = (cnt_ff == '0);
   wire one_m  = (cnt_ff == CNT_WIDTH'(1));
   wire per_m  = (cnt_ff == per_act_ff);

   // Prescaler tick: only the selected low bits take part
   wire [PRESC_WIDTH-1:0] mask = div_mask(clk_div_ff, pre_ff);
   wire presc_tick = ((presc_ff & mask) == mask);

   // External edge detection on synchronised input
   wire ext_rise = ext_s2_ff && !ext_d_ff;
   wire ext_fall = !ext_s2_ff && ext_d_ff;

   // Counting step, a one-cycle enable at the counting clock rate
   wire src_pulse = (src_ff == SRC_PRESC) ? presc_tick :
                    (src_ff == SRC_SOFT)  ? cmd_step :
                    (src_ff == SRC_RISE)  ? ext_rise :
                                            ext_fall;
   wire step = run_ff && src_pulse;

   // End of period for single shot and for shadow transfer timing
   wire per_end_edge   = !align_ff && per_m;
   wire per_end_center = align_ff && dir_ff && one_m;
   wire hw_stop = step && sshot_ff && (per_end_edge || per_end_center);

   // Shadow transfer while enabled: at once when stopped, else at period end
   wire shadow_xfer = ste_ff && (!run_ff || (step && (per_end_edge || per_end_center)));

   // Channel comparators and hysteresis gating
   logic [NUM_CH-1:0] ch_match;
   logic [NUM_CH-1:0] hyst_on;
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         ch_match[i] = (cnt_ff == cmp_act_ff[i]);
         hyst_on[i]  = (mode_ff[4*i +: 4] == MODE_HYST);
      end
   end

   // Run flag: a set command with a nonzero active period beats any clear in the same cycle
   always_comb begin
      nxt_run = run_ff;
      if (cmd_run_clr || hw_stop) begin
         nxt_run = 1'b0;
      end
      if (cmd_run_set && (per_act_ff != '0)) begin
         nxt_run = 1'b1;
      end
   end

   // Shadow enable clears itself after a transfer; a set wins
   always_comb begin
      nxt_ste = ste_ff;
      if (shadow_xfer || cmd_ste_clr) begin
         nxt_ste = 1'b0;
      end
      if (cmd_ste_set) begin
         nxt_ste = 1'b1;
      end
   end

   // Counter and direction
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_dir = dir_ff;
      if (!align_ff) begin
         nxt_dir = 1'b0;
      end
      if (step) begin
         if (!align_ff) begin
            nxt_cnt = per_m ? '0 : cnt_ff + CNT_WIDTH'(1);
         end else begin
            nxt_cnt = dir_ff ? cnt_ff - CNT_WIDTH'(1) : cnt_ff + CNT_WIDTH'(1);
            if (!dir_ff && per_m) begin
               nxt_dir = 1'b1;
            end else if (dir_ff && one_m) begin
               nxt_dir = 1'b0;
            end
         end
      end else if (wr_count && !run_ff) begin
         nxt_cnt = reg_wdata[CNT_WIDTH-1:0];                           // Ignored while running
      end
   end

   // State bits; hardware switching overrides a software write
   always_comb begin
      nxt_state = state_ff;
      for (int i = 0; i < NUM_CH; i++) begin
         if (sw_clr[i]) begin
            nxt_state[i] = 1'b0;
         end
         if (sw_set[i]) begin
            nxt_state[i] = 1'b1;
         end
         if (step) begin
            if (ch_match[i] && !dir_ff) begin
               nxt_state[i] = 1'b1;
            end else if (ch_match[i] && dir_ff) begin
               nxt_state[i] = 1'b0;
            end else if (zero_m && !dir_ff) begin
               nxt_state[i] = 1'b0;
            end
         end
         if (hyst_on[i] && !pos_s2_ff[i]) begin
            nxt_state[i] = 1'b0;
         end
      end
   end

   // Read multiplexer, registered for the next cycle
   wire [31:0] ctrl_rd = {21'h0, dir_ff, run_ff, ste_ff, src_ff, sshot_ff, align_ff, pre_ff, clk_div_ff};
   wire [31:0] rd_mux =
      (reg_addr == ADDR_CTRL)   ? ctrl_rd :
      (reg_addr == ADDR_PERIOD) ? 32'(per_act_ff) :
      (reg_addr == ADDR_CMP0)   ? 32'(cmp_sh_ff[0]) :
      (reg_addr == ADDR_CMP1)   ? 32'(cmp_sh_ff[1]) :
      (reg_addr == ADDR_CMP2)   ? 32'(cmp_sh_ff[2]) :
      (reg_addr == ADDR_STATE)  ? 32'(state_ff) :
      (reg_addr == ADDR_MODE)   ? 32'(mode_ff) :
      (reg_addr == ADDR_COUNT)  ? 32'(cnt_ff) :
                                  READ_UNMAPPED;

   // Input synchronisers on the module clock
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_d_ff  <= 1'b0;
         pos_s1_ff <= '0;
         pos_s2_ff <= '0;
      end else begin
         ext_s1_ff <= external_timer_input;
         ext_s2_ff <= ext_s1_ff;
         ext_d_ff  <= ext_s2_ff;
         pos_s1_ff <= position_input;
         pos_s2_ff <= pos_s1_ff;
      end
   end

   // Prescaler restarts from zero on every start
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         presc_ff <= '0;
      end else if (!run_ff) begin
         presc_ff <= '0;
      end else begin
         presc_ff <= presc_ff + PRESC_WIDTH'(1);
      end
   end

   // Control register and mode register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         clk_div_ff <= 3'h0;
         pre_ff     <= 1'b0;
         align_ff   <= 1'b0;
         sshot_ff   <= 1'b0;
         src_ff     <= SRC_PRESC;
         mode_ff    <= '0;
      end else begin
         if (wr_ctrl) begin
            clk_div_ff <= reg_wdata[CTRL_DIV_LSB +: 3];
            pre_ff     <= reg_wdata[CTRL_PRE_BIT];
            align_ff   <= reg_wdata[CTRL_ALIGN_BIT];
            sshot_ff   <= reg_wdata[CTRL_SSHOT_BIT];
            src_ff     <= ptc_src_type'(reg_wdata[CTRL_SRC_LSB +: 2]);
         end
         if (wr_mode) begin
            mode_ff <= reg_wdata[4*NUM_CH-1:0];
         end
      end
   end

   // Timer core state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         run_ff   <= 1'b0;
         ste_ff   <= 1'b0;
         dir_ff   <= 1'b0;
         cnt_ff   <= COUNT_RST;
         state_ff <= '0;
      end else begin
         run_ff   <= nxt_run;
         ste_ff   <= nxt_ste;
         dir_ff   <= nxt_dir;
         cnt_ff   <= nxt_cnt;
         state_ff <= nxt_state;
      end
   end

   // Shadow and active period and compare values
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         per_sh_ff  <= PERIOD_RST;
         per_act_ff <= PERIOD_RST;
         for (int i = 0; i < NUM_CH; i++) begin
            cmp_sh_ff[i]  <= CMP_RST;
            cmp_act_ff[i] <= CMP_RST;
         end
      end else begin
         if (wr_period) begin
            per_sh_ff <= reg_wdata[CNT_WIDTH-1:0];
         end
         if (shadow_xfer) begin
            per_act_ff <= per_sh_ff;
         end
         for (int i = 0; i < NUM_CH; i++) begin
            if (wr_cmp[i]) begin
               cmp_sh_ff[i] <= reg_wdata[CNT_WIDTH-1:0];
            end
            if (shadow_xfer) begin
               cmp_act_ff[i] <= cmp_sh_ff[i];
            end
         end
      end
   end

   // Match events are one-cycle pulses, independent of state bits
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         up_ev_ff <= '0;
         dn_ev_ff <= '0;
      end else begin
         up_ev_ff <= step && !dir_ff ? ch_match : '0;
         dn_ev_ff <= step && dir_ff ? ch_match : '0;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= READ_UNMAPPED;
      end else begin
         rdata_ff <= reg_rd ? rd_mux : READ_UNMAPPED;
      end
   end

   // Outputs, all from flip-flops except the period_match decode
   assign reg_rdata            = rdata_ff;
   assign channel_state_bit    = state_ff;
   assign up_match_event       = up_ev_ff;
   assign down_match_event     = dn_ev_ff;
   assign main_pwm_counter     = cnt_ff;
   assign count_direction_flag = dir_ff;
   assign run_flag             = run_ff;
   assign period_match         = per_m;   // Decode of counter and period flops
endmodule : ptc_core

// File: test/ptc_core_assertions.sv
`timescale 1ns/100ps
module ptc_core_checker
   import ptc_pkg::*;
#(
   parameter int CNT_WIDTH = 16,
   parameter int NUM_CH    = 3
) (
   input wire logic                 mclk,
   input wire logic                 rstn,
   input wire logic [7:0]           reg_addr,
   input wire logic [31:0]          reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [31:0]          reg_rdata,
   input wire logic [NUM_CH-1:0]    position_input,
   input wire logic [NUM_CH-1:0]    channel_state_bit,
   input wire logic [NUM_CH-1:0]    up_match_event,
   input wire logic [NUM_CH-1:0]    down_match_event,
   input wire logic [CNT_WIDTH-1:0] main_pwm_counter,
   input wire logic                 count_direction_flag,
   input wire logic                 run_flag,
   input wire logic                 period_match
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // Mirror of control and mode words; only the fast prescaler case is timed exactly
   logic [7:0]        ctrl_ff;
   logic [11:0]       mode_ff;
   wire  [NUM_CH-1:0] hyst_w;  // One continuous driver per bit from the generate loop
   wire               fast_w = (ctrl_ff[2:0] == 3'h0) && !ctrl_ff[CTRL_PRE_BIT] && (ctrl_ff[7:6] == SRC_PRESC);
   wire               align_w = ctrl_ff[CTRL_ALIGN_BIT];
   wire               sshot_w = ctrl_ff[CTRL_SSHOT_BIT];

   // Bus writes land at the same edge as in the block
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= 8'h00;
         mode_ff <= 12'h000;
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         ctrl_ff <= reg_wdata[7:0];
      end else if (reg_wr && reg_addr == ADDR_MODE) begin
         mode_ff <= reg_wdata[11:0];
      end
   end

   property p_rd_stands;
      !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
   endproperty
   a_rd_stands: assert property (p_rd_stands) else $error("read data outside its cycle");

   property p_stopped_still;
      !$past(run_flag) && !$past(reg_wr) |-> main_pwm_counter == $past(main_pwm_counter);
   endproperty
   a_stopped_still: assert property (p_stopped_still) else $error("counter moved while stopped");

   property p_up_step;
      $past(run_flag) && !$past(count_direction_flag) && main_pwm_counter != $past(main_pwm_counter)
         |-> main_pwm_counter == $past(main_pwm_counter) + 1'b1 || main_pwm_counter == 16'h0000;
   endproperty
   a_up_step: assert property (p_up_step) else $error("up count step wrong");

   property p_down_step;
      $past(run_flag) && $past(count_direction_flag) && main_pwm_counter != $past(main_pwm_counter)
         |-> main_pwm_counter == $past(main_pwm_counter) - 1'b1;
   endproperty
   a_down_step: assert property (p_down_step) else $error("down count step wrong");

   property p_events;
      |up_match_event |-> $past(run_flag) && !$past(count_direction_flag) && !(|down_match_event);
   endproperty
   a_events: assert property (p_events) else $error("up event without an up step");

   property p_edge_wrap;
      fast_w && !align_w && run_flag && period_match && !reg_wr
         |=> main_pwm_counter == 16'h0000 && !count_direction_flag && run_flag == !sshot_w;
   endproperty
   a_edge_wrap: assert property (p_edge_wrap) else $error("edge wrap or stop wrong");

   property p_turn_down;
      fast_w && align_w && run_flag && period_match && !count_direction_flag && !reg_wr
         |=> count_direction_flag && main_pwm_counter == $past(main_pwm_counter) + 1'b1;
   endproperty
   a_turn_down: assert property (p_turn_down) else $error("no turn down after period");

   property p_turn_up;
      fast_w && align_w && run_flag && count_direction_flag && main_pwm_counter == 16'h0001 && !reg_wr
         |=> !count_direction_flag && main_pwm_counter == 16'h0000 && run_flag == !sshot_w;
   endproperty
   a_turn_up: assert property (p_turn_up) else $error("no turn up or stop at one");

   // Per-channel state rules, all channels share one counter
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      assign hyst_w[i] = mode_ff[4*i+3 -: 4] == MODE_HYST;

      property p_state_set;
         up_match_event[i] && !hyst_w[i] |-> channel_state_bit[i];
      endproperty
      a_state_set: assert property (p_state_set) else $error("state not set on up match");

      property p_state_clr;
         down_match_event[i] |-> !channel_state_bit[i];
      endproperty
      a_state_clr: assert property (p_state_clr) else $error("state not cleared on down match");

      property p_hyst_hold;
         (hyst_w[i] && !position_input[i]) [*4] |-> !channel_state_bit[i];
      endproperty
      a_hyst_hold: assert property (p_hyst_hold) else $error("state not held low");
   end
endmodule : ptc_core_checker

bind ptc_core ptc_core_checker #(.CNT_WIDTH(CNT_WIDTH), .NUM_CH(NUM_CH)) u_chk (
   .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .position_input(position_input),
   .channel_state_bit(channel_state_bit), .up_match_event(up_match_event),
   .down_match_event(down_match_event), .main_pwm_counter(main_pwm_counter),
   .count_direction_flag(count_direction_flag), .run_flag(run_flag), .period_match(period_match)
);

// File: test/ptc_bridge_model.sv
`timescale 1ns/100ps
module ptc_bridge_model (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       edge_req,
   input  wire logic [2:0] pos_req,
   output logic            external_timer_input,
   output logic [2:0]      position_input
);
   // Trigger pin flips once per request; one rise and one fall per pair of requests
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         external_timer_input <= 1'b0;
         position_input       <= 3'h7;
      end else begin
         external_timer_input <= external_timer_input ^ edge_req;
         position_input       <= pos_req; // Comparator output lags the request by a cycle
      end
   end
endmodule : ptc_bridge_model

// File: test/ptc_core_tb.sv
`timescale 1ns/100ps
module ptc_core_tb;
   import ptc_pkg::*;
   logic        mclk, rstn, reg_wr, reg_rd, edge_req, ext_pin;
   logic        count_direction_flag, run_flag, period_match;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [2:0]  pos_req, pos_pin, channel_state_bit, up_match_event, down_match_event;
   logic [15:0] main_pwm_counter, c;
   int          bad_count, total_checks, n, k, pm_cnt, up_cnt;
   int          div_ctl[5] = '{0, 2, 7, 8, 9};
   int          div_exp[5] = '{1, 4, 128, 256, 512};

   ptc_core dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .external_timer_input(ext_pin), .position_input(pos_pin), .channel_state_bit,
      .up_match_event, .down_match_event, .main_pwm_counter, .count_direction_flag, .run_flag, .period_match);
   ptc_bridge_model u_bridge (.mclk, .rstn, .edge_req, .pos_req,
      .external_timer_input(ext_pin), .position_input(pos_pin));

   // Free-running 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic tick_cycle; @(posedge mclk); #1; endtask : tick_cycle

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   task automatic guard(input int cnt, input int lim);
      if (cnt >= lim) begin
         bad_count++;
         $display("MISMATCH at %0t: wait took %h cycles, limit %h", $time, cnt, lim);
         results();
      end
   endtask : guard

   // Bus cycles end just after the taking edge so the effect is already visible
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd

   task automatic wait_run(input logic v);
      for (n = 0; n < 100 && run_flag !== v; n++) tick_cycle();
      guard(n, 100);
   endtask : wait_run

   task automatic wait_move;
      c = main_pwm_counter;
      for (n = 0; n < 40000 && main_pwm_counter === c; n++) tick_cycle();
      guard(n, 40000);
   endtask : wait_move

   // Stop, rewind and select a new count source
   task automatic restart(input logic [31:0] ctl);
      wr(ADDR_CMD, 32'h0000_0002);
      wr(ADDR_COUNT, 32'h0000_0000);
      wr(ADDR_CTRL, ctl);
      wr(ADDR_CMD, 32'h0000_0001);
   endtask : restart

   task automatic ext_pulse;
      @(posedge mclk);
      edge_req <= 1'b1;
      @(posedge mclk);
      edge_req <= 1'b0;
      repeat (6) tick_cycle();
   endtask : ext_pulse

   initial begin
      {rstn, reg_wr, reg_rd, edge_req, reg_addr, reg_wdata} = '0;
      pos_req = 3'h7;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_PERIOD, PERIOD_RST);
      rd(8'hFC, READ_UNMAPPED);
      wr(ADDR_CMD, 32'h0000_0001);
      rd(ADDR_CTRL, 32'h0);
      wr(ADDR_PERIOD, 32'h3);
      wr(ADDR_CMP0, 32'h2);
      wr(ADDR_CMP1, 32'h0);
      wr(ADDR_CMP2, 32'h5);
      rd(ADDR_PERIOD, 32'h0);
      wr(ADDR_CMD, 32'h0000_0008);
      rd(ADDR_PERIOD, 32'h3);
      rd(ADDR_CMP0, 32'h2);
      // Edge-aligned free run, period 4 counting clocks
      wr(ADDR_CMD, 32'h0000_0001);
      wait_run(1'b1);
      {pm_cnt, up_cnt} = '0;
      for (k = 0; k < 16; k++) begin
         tick_cycle();
         pm_cnt += period_match;
         up_cnt += up_match_event[0];
         chk(down_match_event, 3'h0);
      end
      chk(pm_cnt, 4);
      chk(up_cnt, 4);
      // Prescaler: first step and step spacing per divide setting
      for (k = 0; k < 5; k++) begin
         restart(div_ctl[k]);
         wait_move();
         chk(n, div_exp[k]);
         wait_move();
         chk(n, div_exp[k]);
      end
      restart(32'h40);
      for (k = 1; k < 4; k++) begin
         wr(ADDR_CMD, 32'h0000_0004);
         rd(ADDR_COUNT, k);
      end
      wr(ADDR_CMD, 32'h0000_0002);
      wr(ADDR_CMD, 32'h0000_0004);
      rd(ADDR_COUNT, 32'h3);
      for (k = 2; k < 4; k++) begin
         restart(k << CTRL_SRC_LSB);
         ext_pulse();
         ext_pulse();
         ext_pulse();
         ext_pulse();
         rd(ADDR_COUNT, 32'h2);
      end
      // Center-aligned single shot; channel 1 ends set, channel 0 sets then clears, channel 2 never matches
      wr(ADDR_STATE, 32'h0000_0700);
      restart(32'h30);
      wait_run(1'b0);
      chk(n, 8);
      rd(ADDR_COUNT, 32'h0);
      rd(ADDR_STATE, 32'h2);
      chk(channel_state_bit, 3'h2);
      chk(count_direction_flag, 1'b0);
      // Position inputs matter only in the hysteresis-like mode
      pos_req <= 3'h0;
      wr(ADDR_STATE, 32'h1);
      repeat (5) tick_cycle();
      rd(ADDR_STATE, 32'h3);
      wr(ADDR_MODE, 32'h90);
      repeat (5) tick_cycle();
      rd(ADDR_STATE, 32'h1);
      wr(ADDR_STATE, 32'h2);
      rd(ADDR_STATE, 32'h1);
      pos_req <= 3'h7;
      repeat (5) tick_cycle();
      wr(ADDR_STATE, 32'h2);
      rd(ADDR_STATE, 32'h3);
      wr(ADDR_STATE, 32'h0000_0700);
      rd(ADDR_STATE, 32'h0);
      results();
   end
endmodule : ptc_core_tb
